/* bench/lpm_polling_config_tb_top.sv */
`timescale 1ns/1ps
module lpm_polling_config_tb_top;
   import lpm_poll_pkg::*;
   // -----------------------------------------------------------------
   // Bench signals
   // -----------------------------------------------------------------
   // Short debounce keeps the run brief; expectations use the same value.
   localparam int          DEB  = 20;
   localparam logic [21:0] SW   = 22'h2a5c3e;
   localparam logic [31:0] MASK = 32'h003fffff;
   logic [21:0] sw     = SW;
   logic        mclk_i = 1'b0;
   logic        rst_i  = 1'b1;
   logic        sclk, cs_n, mosi, miso, lp_state, lp_start, deb_act;
   logic        fault_ev = 1'b0;
   logic        int_ev   = 1'b0;
   logic        wake     = 1'b0;
   logic        tick     = 1'b0;
   logic [13:0] poll_en, slow, gdeb;
   logic [7:0]  pdeb;
   logic [31:0] rx;
   int          failures, checks_done, starts, c0, c1, dcnt;

   always #5 mclk_i = ~mclk_i;

   spi_host_model host (.mclk_i(mclk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
                        .mosi_o(mosi));

   lpm_polling_config #(.DEB_CYC(DEB)) DUT (
      .mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
      .miso_o(miso), .fault_event_i(fault_ev), .int_event_i(int_ev), .wake_i(wake),
      .switch_state_i(sw), .poll_tick_i(tick), .low_power_state_o(lp_state),
      .lp_start_o(lp_start), .ground_poll_en_o(poll_en), .ground_slow_poll_o(slow),
      .prog_debounce_o(pdeb), .ground_debounce_o(gdeb), .debounce_active_o(deb_act));

   // Pulse and strobe counters; scenarios compare their totals, clearing c0, c1 and dcnt first.
   always @(posedge mclk_i) begin
      if (lp_start === 1'b1) starts++;
      if (tick === 1'b1 && poll_en[0] === 1'b1) c0++;
      if (tick === 1'b1 && poll_en[1] === 1'b1) c1++;
      if (deb_act === 1'b1) dcnt++;
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks_done %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic xfer(input logic [6:0] a, input logic rw, input logic [23:0] d);
      host.frame(a, rw, d, 32, rx);
   endtask

   // Bounded wait for the low-power state; running out ends the run.
   task automatic wait_lp(input logic val);
      int n;
      n = 0;
      while (lp_state !== val && n < 50) begin
         host.hcyc(1);
         n++;
      end
      if (lp_state !== val) begin
         failures++;
         stop_test();
      end
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Replies are pipelined: each frame returns what the previous one addressed, save the first after a wake.
   task automatic s_reset();
      xfer(7'h19, 1'b0, 24'h0);
      xfer(7'h1a, 1'b0, 24'h0);
      check(rx, 32'h00c00000);
      xfer(7'h1b, 1'b0, 24'h0);
      check(rx, 32'h00c00000);
      xfer(7'h1f, 1'b0, 24'h0);
      check(rx, 32'h00c00000);
      check({10'h000, slow, pdeb}, 32'h0);
      check({18'h00000, gdeb}, 32'h0);
   endtask

   // Status reads clear the flags; a later event sets one again.
   task automatic s_flags();
      xfer(7'h15, 1'b0, 24'h0);
      check(rx, {8'h00, 2'b10, sw});
      xfer(7'h19, 1'b0, 24'h0);
      xfer(7'h19, 1'b0, 24'h0);
      check(rx, 32'h0);
      int_ev = 1'b1;
      host.hcyc(1);
      int_ev = 1'b0;
      xfer(7'h19, 1'b1, 24'hffffff);
      check(rx, 32'h00400000);
      fault_ev = 1'b1;
      host.hcyc(1);
      fault_ev = 1'b0;
      xfer(7'h15, 1'b0, 24'h0);
      check(rx, 32'h00c03fff);
   endtask

   // Unused bits drop on write; a read leaves contents alone.
   task automatic s_write();
      xfer(7'h1a, 1'b1, 24'hffffff);
      xfer(7'h1b, 1'b1, 24'hffffff);
      xfer(7'h1a, 1'b0, 24'h000055);
      xfer(7'h19, 1'b0, 24'h0);
      check(rx & MASK, {10'h000, 22'h0000ff});
      xfer(7'h1b, 1'b0, 24'h0);
      check(rx & MASK, {10'h000, 22'h003fff});
      xfer(7'h1b, 1'b0, 24'h0);
      check(rx & MASK, {10'h000, 22'h003fff});
      check({8'h0, slow, pdeb, 2'b00}, {8'h0, 14'h3fff, 8'hff, 2'b00});
      host.frame(7'h1a, 1'b1, 24'h0, 31, rx);
      check({24'h0, pdeb}, 32'hff);
      xfer(7'h19, 1'b1, 24'h000001);
      check({18'h0, slow}, 32'h1);
      check({31'h0, lp_state}, 32'h0);
   endtask

   // Entry, then eight base ticks: channel 0 is slow, channel 1 is not.
   task automatic s_lowpower();
      check(starts, 32'h0);
      xfer(7'h1c, 1'b1, 24'h000000);
      wait_lp(1'b1);
      check({31'h0, lp_state}, 32'h1);
      check(starts, 32'h1);
      c0 = 0;
      c1 = 0;
      dcnt = 0;
      for (int i = 0; i < 8; i++) begin
         tick = 1'b1;
         host.hcyc(1);
         tick = 1'b0;
         host.hcyc(40);
      end
      check(c0, 32'h2);
      check(c1, 32'h8);
      check(dcnt, 8 * DEB);
   endtask

   // Wake: first reply carries both flags and live switch state.
   task automatic s_wake();
      sw = ~SW;
      wake = 1'b1;
      host.hcyc(1);
      wake = 1'b0;
      wait_lp(1'b0);
      xfer(7'h19, 1'b0, 24'h0);
      check(rx, {8'h00, 2'b11, ~SW});
      xfer(7'h19, 1'b0, 24'h0);
      check(rx & MASK, {10'h000, 22'h000001});
      check({24'h0, pdeb}, 32'hff);
   endtask

   // Reset in mid-run restores cleared registers and both flags.
   task automatic s_rerun();
      rst_i = 1'b1;
      host.hcyc(4);
      rst_i = 1'b0;
      host.hcyc(8);
      check({10'h000, slow, pdeb}, 32'h0);
      xfer(7'h1b, 1'b0, 24'h0);
      xfer(7'h1b, 1'b0, 24'h0);
      check(rx, 32'h00c00000);
   endtask

   initial begin
      failures = 0;
      checks_done = 0;
      repeat (16) @(posedge mclk_i);
      #1;
      rst_i = 1'b0;
      host.hcyc(8);
      s_reset();
      s_flags();
      s_write();
      s_lowpower();
      s_wake();
      s_rerun();
      stop_test();
   end
endmodule

/* bench/spi_host_model.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Serial host model
// -----------------------------------------------------------------
// The serial clock idles low and moves only inside a frame.
module spi_host_model (
   // System clock used only to pace the host.
   input  wire logic mclk_i,
   // Serial pins.
   input  wire logic miso_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // Pins move 1 ns after a system edge, so sampling never races them.
   task automatic hcyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   // Eight system cycles per half period give the 160 ns serial clock.
   task automatic frame(input logic [6:0] addr, input logic rw, input logic [23:0] data,
                        input int nbits, output logic [31:0] rx);
      logic [31:0] tx;
      tx = {addr, rw, data};
      rx = 32'h00000000;
      cs_n_o = 1'b0;
      for (int i = 31; i > 31 - nbits; i--) begin
         mosi_o = tx[i];
         hcyc(8);
         sclk_o = 1'b1;
         rx[i] = miso_i;
         hcyc(8);
         sclk_o = 1'b0;
      end
      hcyc(8);
      cs_n_o = 1'b1;
      // A released data line shows the inverse, so a stale level cannot pass.
      mosi_o = ~mosi_o;
      hcyc(12);
   endtask
endmodule

/* pkg/lpm_poll_pkg.sv */
package lpm_poll_pkg;

   // ------------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------------
   localparam int FRAME_BITS  = 32;
   localparam int ADDR_MSB    = 31;
   localparam int ADDR_LSB    = 25;
   localparam int RW_BIT      = 24;
   localparam int DATA_BITS   = 24;
   localparam int FAULT_BIT   = 23;
   localparam int INT_BIT     = 22;
   localparam int REGDATA_MSB = 21;

   // ------------------------------------------------------------------
   // Register addresses (7-bit)
   // ------------------------------------------------------------------
   localparam logic [6:0] ADDR_GROUND_SLOW_POLL   = 7'h19;
   localparam logic [6:0] ADDR_PROG_WAKE_DEBOUNCE = 7'h1a;
   localparam logic [6:0] ADDR_GROUND_WAKE_DEBNC  = 7'h1b;
   localparam logic [6:0] ADDR_LOW_POWER_ENTRY    = 7'h1c;
   localparam logic [6:0] ADDR_SWITCH_STATUS      = 7'h1f;
   localparam logic [6:0] ADDR_FAULT_STATUS       = 7'h15;

   // ------------------------------------------------------------------
   // Channel counts and reset values
   // ------------------------------------------------------------------
   localparam int GROUND_CHANNELS = 14;
   localparam int PROG_CHANNELS   = 8;
   localparam logic [23:0] REG_RESET = 24'h000000;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int  SLOW_POLL_FACTOR = 4;
   localparam real DEBOUNCE_MS      = 1.2;
   localparam real CLK_MHZ          = 100.0;
   localparam int  DEBOUNCE_CYCLES  = int'(DEBOUNCE_MS * CLK_MHZ * 1000.0);

endpackage

/* verilog/link_sync.sv */
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree.
module link_sync
   import lpm_poll_pkg::*;
#(
   parameter int WIDTH = 3
) (
   // Clock and reset.
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // Asynchronous inputs and filtered result.
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // Stage one is only read by stage two, keeping metastability contained.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Per-bit agreement filter.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               sync_o[g] <= 1'b0;
            end else if (s2_q[g] == s3_q[g]) begin
               sync_o[g] <= s3_q[g];
            end
         end
      end
   endgenerate

endmodule

/* verilog/lpm_polling_config.sv */
`timescale 1ns/1ps
//
// Operation
// RL1 - 32-bit frame: address, write flag, data
// RL2 - Reply: fault bit 23, interrupt 22, data
// RL3 - Base polling rate comes from outside
// RL4 - Slow bit set polls four times slower
// RL5 - Ground slow-poll register, 14 bits, clear
// RL6 - Debounce bit clear: voltage-difference detection
// RL7 - Debounce bit set: extra 1.2 ms current
// RL8 - Programmable debounce register, 8 bits, clear
// RL9 - Ground debounce register, 14 bits, clear
// RL10 - Only entry command enters low power
// RL11 - Host sends entry with zero data
// RL12 - Entry register write only, no reply
// RL13 - Entry starts polling and interrupt timer
// RL14 - Registers kept across low power exit
// RL15 - First frame after wake reports flags set
// RL16 - Status read clears interrupt; fault read
// RL17 - Flags returned in reply to commands
// RL18 - Write flag one writes, zero reads
// RL19 - Unused bits ignored, read as zero
module lpm_polling_config
   import lpm_poll_pkg::*;
#(
   parameter int GCH     = GROUND_CHANNELS,
   parameter int PCH     = PROG_CHANNELS,
   parameter int DEB_CYC = DEBOUNCE_CYCLES
) (
   // Clock and reset.
   input  wire logic           mclk_i,
   input  wire logic           rst_i,
   // Serial port pins.
   input  wire logic           sclk_i,
   input  wire logic           cs_n_i,
   input  wire logic           mosi_i,
   output logic                miso_o,
   // Device status in.
   input  wire logic           fault_event_i,
   input  wire logic           int_event_i,
   input  wire logic           wake_i,
   input  wire logic [21:0]    switch_state_i,
   input  wire logic           poll_tick_i,
   // Low-power engine controls.
   output logic                low_power_state_o,
   output logic                lp_start_o,
   output logic [GCH-1:0]      ground_poll_en_o,
   output logic [GCH-1:0]      ground_slow_poll_o,
   output logic [PCH-1:0]      prog_debounce_o,
   output logic [GCH-1:0]      ground_debounce_o,
   output logic                debounce_active_o
);

   // Refuse channel counts the reply word cannot carry, and windows too short to check.
   if (GCH < 1 || GCH > REGDATA_MSB + 1 || PCH < 1 || PCH > REGDATA_MSB + 1 ||
       DEB_CYC < 8) begin : g_bad_params
      $error("lpm_polling_config: unsupported parameters");
   end

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [2:0] pins_s;
   link_sync #(.WIDTH(3)) u_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i ({sclk_i, ~cs_n_i, mosi_i}), // Select inverted: cleared stages read idle.
      .sync_o  (pins_s)
   );

   logic sclk_s;
   logic cs_n_s;
   logic mosi_s;
   logic sclk_prev_q;
   logic cs_prev_q;
   assign sclk_s = pins_s[2];
   assign cs_n_s = ~pins_s[1];
   assign mosi_s = pins_s[0];

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_s;
         cs_prev_q   <= cs_n_s;
      end
   end

   logic rise;
   logic fall;
   logic cs_start;
   logic cs_end;
   assign rise     = sclk_s & ~sclk_prev_q & ~cs_n_s;
   assign fall     = ~sclk_s & sclk_prev_q & ~cs_n_s;
   assign cs_start = ~cs_n_s & cs_prev_q;
   assign cs_end   = cs_n_s & ~cs_prev_q;

   // ------------------------------------------------------------------
   // Frame shifter
   // ------------------------------------------------------------------
   logic [FRAME_BITS-1:0] rx_q;
   logic [FRAME_BITS-1:0] tx_q;
   logic [5:0]            cnt_q;
   logic                  frame_ok;
   logic [6:0]            f_addr;
   logic                  f_wr;
   logic [DATA_BITS-1:0]  f_data;

   assign frame_ok = cs_end && (cnt_q == 6'(FRAME_BITS));
   assign f_addr   = rx_q[ADDR_MSB:ADDR_LSB]; // RL1
   assign f_wr     = rx_q[RW_BIT]; // RL18
   assign f_data   = rx_q[DATA_BITS-1:0];

   // Sample on rising clock edges, count bits; short frames are dropped.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rx_q  <= '0;
         cnt_q <= '0;
      end else if (cs_start) begin
         cnt_q <= '0;
      end else if (rise) begin
         rx_q  <= {rx_q[FRAME_BITS-2:0], mosi_s}; // RL1
         if (cnt_q != 6'h3f)
            cnt_q <= cnt_q + 6'h01;
      end
   end

   // ------------------------------------------------------------------
   // Flags and low-power state
   // ------------------------------------------------------------------
   logic fault_q;
   logic int_q;
   logic lp_q;
   logic wake_s_q;
   logic wake_pend_q;
   logic entry_cmd;
   logic rd_status;
   logic rd_fault;

   assign entry_cmd = frame_ok && f_addr == ADDR_LOW_POWER_ENTRY && f_wr; // RL10
   assign rd_status = frame_ok && f_addr == ADDR_SWITCH_STATUS && !f_wr;
   assign rd_fault  = frame_ok && f_addr == ADDR_FAULT_STATUS && !f_wr;

   // Flags set at power-on; an event in the clearing cycle wins.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         fault_q <= 1'b1;
         int_q   <= 1'b1;
      end else begin
         if (fault_event_i || (lp_q && wake_i))
            fault_q <= 1'b1; // RL15
         else if (rd_fault)
            fault_q <= 1'b0; // RL16
         if (int_event_i || (lp_q && wake_i))
            int_q <= 1'b1; // RL15
         else if (rd_status)
            int_q <= 1'b0; // RL16
      end
   end

   // Low power is only entered by the command; wake returns to normal.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         lp_q        <= 1'b0;
         wake_pend_q <= 1'b0;
         wake_s_q    <= 1'b0;
      end else begin
         wake_s_q <= 1'b0;
         if (lp_q && wake_i) begin
            lp_q        <= 1'b0;
            wake_pend_q <= 1'b1;
         end else if (entry_cmd) begin
            lp_q     <= 1'b1; // RL13
            wake_s_q <= 1'b1;
         end
         if (frame_ok && !(lp_q && wake_i))
            wake_pend_q <= 1'b0;
      end
   end

   assign low_power_state_o = lp_q;
   assign lp_start_o        = wake_s_q; // RL13

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   logic [GCH-1:0] gslow_q;
   logic [PCH-1:0] pdeb_q;
   logic [GCH-1:0] gdeb_q;

   // Writes update only implemented bits; register values are not touched
   // by entering or leaving low power.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         gslow_q <= GCH'(REG_RESET); // RL5
         pdeb_q  <= PCH'(REG_RESET); // RL8
         gdeb_q  <= GCH'(REG_RESET); // RL9
      end else if (frame_ok && f_wr) begin // RL14
         if (f_addr == ADDR_GROUND_SLOW_POLL)
            gslow_q <= f_data[GCH-1:0]; // RL19
         if (f_addr == ADDR_PROG_WAKE_DEBOUNCE)
            pdeb_q <= f_data[PCH-1:0]; // RL19
         if (f_addr == ADDR_GROUND_WAKE_DEBNC)
            gdeb_q <= f_data[GCH-1:0]; // RL19
      end
   end

   assign ground_slow_poll_o = gslow_q;
   assign prog_debounce_o    = pdeb_q; // RL6
   assign ground_debounce_o  = gdeb_q; // RL6

   // ------------------------------------------------------------------
   // Slow-polling divider: base tick comes from outside on poll_tick_i.
   // ------------------------------------------------------------------
   logic [1:0] div_q;
   always_ff @(posedge mclk_i) begin
      if (rst_i)
         div_q <= '0;
      else if (poll_tick_i && lp_q)
         div_q <= div_q + 2'h1; // RL3
   end

   genvar c;
   generate
      for (c = 0; c < GCH; c++) begin : g_poll
         assign ground_poll_en_o[c] = poll_tick_i && lp_q &&
                                      (!gslow_q[c] || div_q == 2'(SLOW_POLL_FACTOR - 1)); // RL4
      end
   endgenerate

   // ------------------------------------------------------------------
   // Debounce window: keep polling current on for the extended time.
   // ------------------------------------------------------------------
   logic [$clog2(DEB_CYC+1)-1:0] deb_q;
   always_ff @(posedge mclk_i) begin
      if (rst_i)
         deb_q <= '0;
      else if (poll_tick_i && lp_q && (|pdeb_q || |gdeb_q))
         deb_q <= ($clog2(DEB_CYC+1))'(DEB_CYC); // RL7
      else if (deb_q != '0)
         deb_q <= deb_q - 1'b1;
   end
   assign debounce_active_o = deb_q != '0; // RL7

   // ------------------------------------------------------------------
   // Reply word, loaded at frame start and shifted on falling edges.
   // ------------------------------------------------------------------
   logic [REGDATA_MSB:0] rd_data;
   always_comb begin
      rd_data = '0;
      unique case (rx_q[ADDR_MSB:ADDR_LSB])
         ADDR_GROUND_SLOW_POLL:   rd_data = 22'(gslow_q);
         ADDR_PROG_WAKE_DEBOUNCE: rd_data = 22'(pdeb_q);
         ADDR_GROUND_WAKE_DEBNC:  rd_data = 22'(gdeb_q);
         ADDR_SWITCH_STATUS:      rd_data = switch_state_i;
         default:                 rd_data = '0;
      endcase
   end

   // Reply reflects previous frame's address; after wake, switch state.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tx_q <= '0;
      end else if (cs_start) begin
         if (wake_pend_q)
            tx_q <= {8'h00, fault_q, int_q, switch_state_i}; // RL15
         else if (rx_q[ADDR_MSB:ADDR_LSB] == ADDR_LOW_POWER_ENTRY)
            tx_q <= {8'h00, fault_q, int_q, 22'h000000}; // RL12
         else
            tx_q <= {8'h00, fault_q, int_q, rd_data}; // RL2 RL17
      end else if (fall) begin
         tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
      end
   end
   assign miso_o = tx_q[FRAME_BITS-1];

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_entry_only_cmd: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(lp_q) |-> $past(entry_cmd)) else $error("low power entered without command"); // RL10
   a_write_updates_slow: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_ok && f_wr && f_addr == ADDR_GROUND_SLOW_POLL |=> gslow_q == $past(f_data[GCH-1:0]))
      else $error("slow poll write lost"); // RL5
   a_read_keeps_regs: assert property (@(posedge mclk_i) disable iff (rst_i)
      frame_ok && !f_wr |=> $stable(pdeb_q) && $stable(gdeb_q) && $stable(gslow_q))
      else $error("read changed register"); // RL18
   a_int_clear_status: assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_status && !int_event_i && !(lp_q && wake_i) |=> !int_q)
      else $error("interrupt flag not cleared"); // RL16
   a_fault_holds_set: assert property (@(posedge mclk_i) disable iff (rst_i)
      fault_q && !rd_fault |=> fault_q) else $error("fault flag dropped"); // RL16
   a_wake_flags_set: assert property (@(posedge mclk_i) disable iff (rst_i)
      lp_q && wake_i |=> fault_q && int_q && !lp_q) else $error("wake flags not set"); // RL15
   a_slow_poll_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
      ground_poll_en_o[0] && gslow_q[0] |-> div_q == 2'(SLOW_POLL_FACTOR - 1))
      else $error("slow poll too fast"); // RL4
   a_debounce_window: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(debounce_active_o) |-> debounce_active_o [*8]) else $error("debounce too short"); // RL7
   a_lp_start_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
      lp_start_o |-> lp_q ##1 !lp_start_o) else $error("start pulse wrong"); // RL13

endmodule
